// >>> core/fsgp_pkg.sv
// package: constants for the flash protection host controller
package fsgp_pkg;
    // ==========================================
    // operations
    typedef enum logic [2:0] {
        FSGP_OP_PROTECT   = 3'b000,
        FSGP_OP_UNPROTECT = 3'b001,
        FSGP_OP_VERIFY    = 3'b010,
        FSGP_OP_SEC_ENTER = 3'b011,
        FSGP_OP_SEC_LOCK  = 3'b100,
        FSGP_OP_SEC_EXIT  = 3'b101,
        FSGP_OP_TEMP_ON   = 3'b110,
        FSGP_OP_TEMP_OFF  = 3'b111
    } fsgp_op_e;
    // ==========================================
    // bus geometry
    localparam int FSGP_AW = 23;
    localparam int FSGP_DW = 16;
    localparam int FSGP_GROUP_HI = 22;
    localparam int FSGP_GROUP_LO = 15;
    localparam int FSGP_NUM_GROUPS = 70;
    // ==========================================
    // command words
    localparam logic [FSGP_AW-1:0] FSGP_UNLOCK_ADDR1 = 23'h000555;
    localparam logic [FSGP_AW-1:0] FSGP_UNLOCK_ADDR2 = 23'h0002aa;
    localparam logic [7:0] FSGP_UNLOCK_DATA1 = 8'haa;
    localparam logic [7:0] FSGP_UNLOCK_DATA2 = 8'h55;
    localparam logic [7:0] FSGP_SEC_ENTER_DATA = 8'h88;
    localparam logic [7:0] FSGP_SEC_EXIT_DATA = 8'h90;
    localparam logic [7:0] FSGP_SEC_EXIT_DATA2 = 8'h00;
    localparam logic [7:0] FSGP_PROT_DATA = 8'h60;
    localparam logic [FSGP_AW-1:0] FSGP_PROT_SEL = 23'h000002;
    localparam logic [FSGP_AW-1:0] FSGP_UNPROT_SEL = 23'h000042;
    localparam logic [7:0] FSGP_VERIFY_DATA = 8'h40;
    localparam logic [7:0] FSGP_PROTECTED_CODE = 8'h01;
    localparam logic [7:0] FSGP_UNPROTECTED_CODE = 8'h00;
    // ==========================================
    // timing (ns and cycles at 100 MHz)
    localparam int FSGP_CLK_NS = 10;
    localparam int FSGP_WE_LOW_NS = 35;
    localparam int FSGP_WE_HIGH_NS = 30;
    localparam int FSGP_RD_ACCESS_NS = 90;
    localparam logic [3:0] FSGP_WE_LOW_CYC = 4'((FSGP_WE_LOW_NS + FSGP_CLK_NS - 1) / FSGP_CLK_NS);
    localparam logic [3:0] FSGP_WE_HIGH_CYC = 4'((FSGP_WE_HIGH_NS + FSGP_CLK_NS - 1) / FSGP_CLK_NS);
    localparam logic [3:0] FSGP_RD_CYC = 4'((FSGP_RD_ACCESS_NS + FSGP_CLK_NS - 1) / FSGP_CLK_NS);
endpackage

// >>> core/fsgp_cyc_if.sv
// interface: one bus cycle request between sequencer and cycle engine
`timescale 1ns/10ps
`default_nettype none
interface fsgp_cyc_if;
    logic req;
    logic wr;
    logic [22:0] addr;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
    modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// >>> core/fsgp_cycle.sv
// module: single flash bus cycle engine with standard cpu timing
`timescale 1ns/10ps
`default_nettype none
module fsgp_cycle
    import fsgp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    fsgp_cyc_if.eng cyc,
    output logic ce_b,
    output logic oe_b,
    output logic we_b,
    output logic [FSGP_AW-1:0] addr,
    output logic [FSGP_DW-1:0] dq_o,
    output logic dq_oe_b,
    input wire logic [FSGP_DW-1:0] dq_i
);
    import fsgp_pkg::*;
    typedef enum logic [1:0] {
        FSGP_C_IDLE = 2'b00,
        FSGP_C_LOW = 2'b01,
        FSGP_C_HIGH = 2'b10
    } fsgp_cst_e;
    fsgp_cst_e st_reg;
    logic [3:0] cnt_reg;
    logic wr_reg;
    // ==========================================
    // strobe sequencing; plain write timing, no high voltage on data pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= FSGP_C_IDLE;
            cnt_reg <= 4'h0;
            wr_reg <= 1'b0;
            ce_b <= 1'b1;
            oe_b <= 1'b1;
            we_b <= 1'b1;
            addr <= '0;
            dq_o <= '0;
            dq_oe_b <= 1'b1;
            cyc.done <= 1'b0;
            cyc.rdata <= '0;
        end else begin
            cyc.done <= 1'b0;
            unique case (st_reg)
                FSGP_C_IDLE: if (cyc.req) begin
                    st_reg <= FSGP_C_LOW;
                    wr_reg <= cyc.wr;
                    addr <= cyc.addr;
                    dq_o <= cyc.wdata;
                    dq_oe_b <= !cyc.wr;
                    ce_b <= 1'b0;
                    we_b <= !cyc.wr;
                    oe_b <= cyc.wr;
                    cnt_reg <= cyc.wr ? FSGP_WE_LOW_CYC : FSGP_RD_CYC;
                end
                FSGP_C_LOW: if (cnt_reg > 4'h1) begin
                    cnt_reg <= cnt_reg - 4'h1;
                end else begin
                    if (!wr_reg) begin
                        cyc.rdata <= dq_i;
                    end
                    we_b <= 1'b1;
                    oe_b <= 1'b1;
                    ce_b <= 1'b1;
                    cnt_reg <= FSGP_WE_HIGH_CYC;
                    st_reg <= FSGP_C_HIGH;
                end
                FSGP_C_HIGH: if (cnt_reg > 4'h1) begin
                    cnt_reg <= cnt_reg - 4'h1;
                end else begin
                    dq_oe_b <= 1'b1;
                    cyc.done <= 1'b1;
                    st_reg <= FSGP_C_IDLE;
                end
                default: st_reg <= FSGP_C_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> core/fsgp_host.sv
// module: host controller driving flash sector group protection
`timescale 1ns/10ps
`default_nettype none
// ==========================================
module fsgp_host
    import fsgp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CMD_VALID,
    input wire fsgp_pkg::fsgp_op_e CMD_OP,
    input wire logic [7:0] CMD_GROUP,
    output logic CMD_READY,
    output logic DONE,
    output logic VERIFY_PROT,
    output logic SEC_MAPPED,
    output logic HV_MODE,
    output logic ERR,
    output logic FLASH_CE_B,
    output logic FLASH_OE_B,
    output logic FLASH_WE_B,
    output logic [fsgp_pkg::FSGP_AW-1:0] FLASH_ADDR,
    output logic [fsgp_pkg::FSGP_DW-1:0] FLASH_DQ_O,
    output logic FLASH_DQ_OE_B,
    input wire logic [fsgp_pkg::FSGP_DW-1:0] FLASH_DQ_I,
    output logic FLASH_RESET_HV,
    output logic FLASH_RESET_B,
    output logic EDGE_GROUP_LOCK_PIN
);
    import fsgp_pkg::*;
    typedef enum logic [2:0] {
        FSGP_IDLE = 3'b000,
        FSGP_ISSUE = 3'b001,
        FSGP_WAIT = 3'b010,
        FSGP_FIN = 3'b011
    } fsgp_st_e;
    fsgp_cyc_if cyc();
    fsgp_st_e st_reg;
    fsgp_op_e op_reg;
    logic [7:0] grp_reg;
    logic [2:0] step_reg;
    logic [2:0] last_step;
    logic [FSGP_NUM_GROUPS-1:0] seen_prot_reg;
    // ==========================================
    // group base address from upper address bits
    function automatic logic [FSGP_AW-1:0] group_addr(input logic [7:0] g);
        logic [7:0] ub;
        ub = g;
        if (g > 8'h03 && g < 8'hfc) begin
            ub = {g[7:2], 2'b00};
        end
        return {ub, 15'h0000};
    endfunction
    function automatic logic [6:0] group_index(input logic [7:0] g);
        logic [6:0] idx;
        idx = 7'(g >> 2) + 7'h03;
        if (g < 8'h04) begin
            idx = g[6:0];
        end else if (g >= 8'hfc) begin
            idx = 7'(g - 8'hfc) + 7'(FSGP_NUM_GROUPS - 4);
        end
        return idx;
    endfunction
    // ==========================================
    // per-command cycle list
    always_comb begin
        last_step = 3'h2;
        unique case (op_reg)
            FSGP_OP_PROTECT, FSGP_OP_UNPROTECT: last_step = 3'h2;
            FSGP_OP_VERIFY: last_step = 3'h1;
            FSGP_OP_SEC_ENTER: last_step = 3'h2;
            FSGP_OP_SEC_LOCK: last_step = 3'h2;
            FSGP_OP_SEC_EXIT: last_step = 3'h3;
            FSGP_OP_TEMP_ON, FSGP_OP_TEMP_OFF: last_step = 3'h0;
        endcase
    end
    always_comb begin
        cyc.wr = 1'b1;
        cyc.addr = FSGP_UNLOCK_ADDR1;
        cyc.wdata = {8'h00, FSGP_UNLOCK_DATA1};
        unique case (op_reg)
            FSGP_OP_PROTECT, FSGP_OP_UNPROTECT, FSGP_OP_SEC_LOCK: begin
                cyc.addr = group_addr(grp_reg) | ((op_reg == FSGP_OP_UNPROTECT) ? FSGP_UNPROT_SEL : FSGP_PROT_SEL);
                cyc.wdata = {8'h00, (step_reg == 3'h2) ? FSGP_VERIFY_DATA : FSGP_PROT_DATA};
                cyc.wr = (step_reg != 3'h2);
            end
            FSGP_OP_VERIFY: begin
                cyc.addr = group_addr(grp_reg) | FSGP_PROT_SEL;
                cyc.wdata = {8'h00, FSGP_VERIFY_DATA};
                cyc.wr = (step_reg == 3'h0);
            end
            FSGP_OP_SEC_ENTER, FSGP_OP_SEC_EXIT: begin
                if (step_reg == 3'h1) begin
                    cyc.addr = FSGP_UNLOCK_ADDR2;
                    cyc.wdata = {8'h00, FSGP_UNLOCK_DATA2};
                end else if (step_reg == 3'h2) begin
                    cyc.wdata = {8'h00, (op_reg == FSGP_OP_SEC_ENTER) ? FSGP_SEC_ENTER_DATA : FSGP_SEC_EXIT_DATA};
                end else if (step_reg == 3'h3) begin
                    cyc.addr = '0;
                    cyc.wdata = {8'h00, FSGP_SEC_EXIT_DATA2};
                end
            end
            FSGP_OP_TEMP_ON, FSGP_OP_TEMP_OFF: begin
                cyc.wr = 1'b1;
            end
        endcase
    end
    // ==========================================
    // sequencer
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_reg <= FSGP_IDLE;
            op_reg <= FSGP_OP_PROTECT;
            grp_reg <= 8'h00;
            step_reg <= 3'h0;
            cyc.req <= 1'b0;
            CMD_READY <= 1'b0;
            DONE <= 1'b0;
            ERR <= 1'b0;
        end else begin
            DONE <= 1'b0;
            cyc.req <= 1'b0;
            unique case (st_reg)
                FSGP_IDLE: begin
                    CMD_READY <= 1'b1;
                    if (CMD_VALID && CMD_READY) begin
                        CMD_READY <= 1'b0;
                        op_reg <= CMD_OP;
                        grp_reg <= CMD_GROUP;
                        step_reg <= 3'h0;
                        ERR <= 1'b0;
                        // unprotect refused until every group was protected once
                        if (CMD_OP == FSGP_OP_UNPROTECT && !(&seen_prot_reg)) begin
                            ERR <= 1'b1;
                            st_reg <= FSGP_FIN;
                        end else if (CMD_OP == FSGP_OP_SEC_LOCK && !SEC_MAPPED) begin
                            ERR <= 1'b1;
                            st_reg <= FSGP_FIN;
                        end else if (CMD_OP == FSGP_OP_TEMP_ON || CMD_OP == FSGP_OP_TEMP_OFF) begin
                            st_reg <= FSGP_FIN;
                        end else begin
                            st_reg <= FSGP_ISSUE;
                        end
                    end
                end
                FSGP_ISSUE: begin
                    cyc.req <= 1'b1;
                    st_reg <= FSGP_WAIT;
                end
                FSGP_WAIT: if (cyc.done) begin
                    if (step_reg == last_step) begin
                        st_reg <= FSGP_FIN;
                    end else begin
                        step_reg <= step_reg + 3'h1;
                        st_reg <= FSGP_ISSUE;
                    end
                end
                FSGP_FIN: begin
                    DONE <= 1'b1;
                    st_reg <= FSGP_IDLE;
                end
                default: st_reg <= FSGP_IDLE;
            endcase
        end
    end
    // ==========================================
    // verify result; only low byte carries the code
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            VERIFY_PROT <= 1'b0;
        end else if (st_reg == FSGP_WAIT && cyc.done && !cyc.wr) begin
            VERIFY_PROT <= (cyc.rdata[7:0] == FSGP_PROTECTED_CODE);
        end
    end
    // tracks which groups this host protected; volatile, so a host reset forgets it
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            seen_prot_reg <= '0;
        end else if (st_reg == FSGP_FIN && !ERR && op_reg == FSGP_OP_PROTECT) begin
            seen_prot_reg[group_index(grp_reg)] <= 1'b1;
        end
    end
    // ==========================================
    // secured region mapping and high voltage control
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            SEC_MAPPED <= 1'b0;
            HV_MODE <= 1'b0;
            FLASH_RESET_HV <= 1'b0;
            FLASH_RESET_B <= 1'b0;
            EDGE_GROUP_LOCK_PIN <= 1'b1;
        end else begin
            FLASH_RESET_B <= 1'b1;
            // protect and unprotect need the high level on the reset pin; refused commands never raise it
            if (st_reg == FSGP_IDLE && CMD_VALID && CMD_READY
                && (CMD_OP == FSGP_OP_PROTECT || (CMD_OP == FSGP_OP_UNPROTECT && &seen_prot_reg))) begin
                FLASH_RESET_HV <= 1'b1;
            end
            if (st_reg == FSGP_FIN && (op_reg == FSGP_OP_PROTECT || op_reg == FSGP_OP_UNPROTECT)) begin
                FLASH_RESET_HV <= HV_MODE;
            end
            if (st_reg == FSGP_FIN && op_reg == FSGP_OP_SEC_ENTER) begin
                SEC_MAPPED <= 1'b1;
            end
            if (st_reg == FSGP_FIN && op_reg == FSGP_OP_SEC_EXIT) begin
                SEC_MAPPED <= 1'b0;
            end
            if (st_reg == FSGP_FIN && op_reg == FSGP_OP_TEMP_ON) begin
                HV_MODE <= 1'b1;
                FLASH_RESET_HV <= 1'b1;
            end
            if (st_reg == FSGP_FIN && op_reg == FSGP_OP_TEMP_OFF) begin
                HV_MODE <= 1'b0;
                FLASH_RESET_HV <= 1'b0;
            end
        end
    end
    fsgp_cycle u_cycle (
        .clk(CLK),
        .rst_b(RST_B),
        .cyc(cyc.eng),
        .ce_b(FLASH_CE_B),
        .oe_b(FLASH_OE_B),
        .we_b(FLASH_WE_B),
        .addr(FLASH_ADDR),
        .dq_o(FLASH_DQ_O),
        .dq_oe_b(FLASH_DQ_OE_B),
        .dq_i(FLASH_DQ_I)
    );
endmodule
`default_nettype wire

// >>> bench/fsgp_flash_model.sv
// behavioural flash device answering the host controller's protection traffic
`timescale 1ns/10ps
`default_nettype none
module fsgp_flash_model
    import fsgp_pkg::*;
(
    input wire logic ce_b,
    input wire logic oe_b,
    input wire logic we_b,
    input wire logic reset_b,
    input wire logic [FSGP_AW-1:0] addr,
    input wire logic [FSGP_DW-1:0] dq_in,
    input wire logic reset_hv,
    input wire logic edge_lock_pin,
    output logic [FSGP_DW-1:0] dq_out
);
    // ==========================================
    // state; customer-lockable variant whose lock pin guards the first group
    localparam bit FACTORY_LOCKED = 1'b0;
    localparam int LOCK_GROUP = 0;
    logic [FSGP_NUM_GROUPS-1:0] prot_reg = '0;
    logic [FSGP_NUM_GROUPS-1:0] modifiable;
    logic [FSGP_DW-1:0] sec_mem [0:127];
    logic sec_mapped = 1'b0;
    logic sec_locked = FACTORY_LOCKED;
    logic bypass = 1'b0;
    logic [1:0] stage = 2'h0;
    logic [7:0] rd_low;
    logic [FSGP_DW-1:0] rd_word;
    // pulled up: an open or floating pin never locks
    wire logic lock_low = (edge_lock_pin === 1'b0);
    // a write ends on whichever of enable and write strobe rises first
    wire logic wr_act = !ce_b && !we_b && oe_b;
    function automatic int gidx(input logic [7:0] g);
        return g < 4 ? int'(g) : (g > 251 ? int'(g) - 186 : 4 + (int'(g) - 4) / 4);
    endfunction
    initial begin
        for (int i = 0; i < 128; i++) begin
            sec_mem[i] = (FACTORY_LOCKED && i < 8) ? 16'(16'h5e00 + i) : 16'hffff;
        end
    end
    // ==========================================
    // program and erase gate per group
    always_comb begin
        for (int i = 0; i < FSGP_NUM_GROUPS; i++) begin
            modifiable[i] = !prot_reg[i] || reset_hv;
        end
        if (lock_low) begin
            modifiable[LOCK_GROUP] = 1'b0;
        end
    end
    // ==========================================
    // reset drops the mapping, bypass and unlock stage; group cells are nonvolatile
    always @(negedge reset_b or negedge wr_act) begin
        if (!reset_b) begin
            sec_mapped <= 1'b0;
            bypass <= 1'b0;
            stage <= 2'h0;
        end else if (reset_b) begin
            if (dq_in[7:0] == 8'h60 && addr[7:0] == 8'h02) begin
                if (sec_mapped)
                    sec_locked <= 1'b1;
                else if (reset_hv)
                    prot_reg[gidx(addr[22:15])] <= 1'b1;
            end
            if (dq_in[7:0] == 8'h60 && addr[7:0] == 8'h42 && !sec_mapped && reset_hv)
                prot_reg <= '0;
            if (dq_in[7:0] == 8'haa && addr == 23'h000555)
                stage <= 2'h1;
            else if (stage == 2'h1 && dq_in[7:0] == 8'h55 && addr == 23'h0002aa)
                stage <= 2'h2;
            else if (stage == 2'h2 && dq_in[7:0] == 8'h90)
                stage <= 2'h3;
            else
                stage <= 2'h0;
            if (stage == 2'h2 && dq_in[7:0] == 8'h88)
                sec_mapped <= 1'b1;
            if (stage == 2'h2 && dq_in[7:0] == 8'h20)
                bypass <= !sec_mapped;
            if (stage == 2'h3 && dq_in[7:0] == 8'h00)
                sec_mapped <= 1'b0;
        end
    end
    // ==========================================
    // reads: first-sector addresses hit the secured region while mapped
    always_comb begin
        rd_low = {7'h00, prot_reg[gidx(addr[22:15])]};
        if (addr[1:0] == 2'b11) begin
            rd_low = {FACTORY_LOCKED, 7'h08};
        end
        rd_word = {8'h00, rd_low};
        if (sec_mapped && addr[22:15] == 8'h00) begin
            rd_word = sec_mem[addr[6:0]];
        end
    end
    // a released bus shows the inverse, so a late sample is caught
    assign dq_out = (ce_b | oe_b) ? ~rd_word : rd_word;
endmodule
`default_nettype wire

// >>> bench/fsgp_host_props.sv
// checker: port-level timing relations of the protection host controller
`timescale 1ns/10ps
`default_nettype none
module fsgp_host_props
    import fsgp_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CMD_VALID,
    input wire fsgp_pkg::fsgp_op_e CMD_OP,
    input wire logic CMD_READY,
    input wire logic DONE,
    input wire logic ERR,
    input wire logic SEC_MAPPED,
    input wire logic FLASH_WE_B,
    input wire logic FLASH_OE_B,
    input wire logic [fsgp_pkg::FSGP_DW-1:0] FLASH_DQ_O,
    input wire logic FLASH_DQ_OE_B,
    input wire logic FLASH_RESET_HV,
    input wire logic FLASH_RESET_B,
    input wire logic EDGE_GROUP_LOCK_PIN
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    wire take = CMD_VALID && CMD_READY;
    // ==========================================
    // properties
    property p_done_pulse; DONE |=> !DONE && CMD_READY; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
    property p_take_busy; take |=> !CMD_READY; endproperty
    a_take_busy: assert property (p_take_busy) else $error("ready stayed high after take");
    property p_strobe_excl; !(!FLASH_WE_B && !FLASH_OE_B); endproperty
    a_strobe_excl: assert property (p_strobe_excl) else $error("write and read strobes both low");
    property p_we_drives; !FLASH_WE_B |-> !FLASH_DQ_OE_B && FLASH_DQ_O[15:8] == 8'h00; endproperty
    a_we_drives: assert property (p_we_drives) else $error("data not driven in write");
    property p_we_width; $fell(FLASH_WE_B) |-> (!FLASH_WE_B) [*3] ##[1:2] FLASH_WE_B; endproperty
    a_we_width: assert property (p_we_width) else $error("write strobe width wrong");
    property p_lock_refuse;
        take && CMD_OP == FSGP_OP_SEC_LOCK && !SEC_MAPPED |-> ##[1:3] (DONE && ERR && FLASH_WE_B);
    endproperty
    a_lock_refuse: assert property (p_lock_refuse) else $error("unmapped lock not refused");
    property p_hv_on; take && CMD_OP == FSGP_OP_TEMP_ON |-> ##[1:3] FLASH_RESET_HV; endproperty
    a_hv_on: assert property (p_hv_on) else $error("high voltage not applied");
    property p_hv_off; take && CMD_OP == FSGP_OP_TEMP_OFF |-> ##[1:3] !FLASH_RESET_HV; endproperty
    a_hv_off: assert property (p_hv_off) else $error("high voltage not removed");
    property p_pins_idle; CMD_READY |-> EDGE_GROUP_LOCK_PIN && FLASH_RESET_B; endproperty
    a_pins_idle: assert property (p_pins_idle) else $error("lock or reset pin low when idle");
endmodule
bind fsgp_host fsgp_host_props u_props (.CLK(CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP),
    .CMD_READY(CMD_READY), .DONE(DONE), .ERR(ERR), .SEC_MAPPED(SEC_MAPPED), .FLASH_WE_B(FLASH_WE_B),
    .FLASH_OE_B(FLASH_OE_B), .FLASH_DQ_O(FLASH_DQ_O), .FLASH_DQ_OE_B(FLASH_DQ_OE_B),
    .FLASH_RESET_HV(FLASH_RESET_HV), .FLASH_RESET_B(FLASH_RESET_B), .EDGE_GROUP_LOCK_PIN(EDGE_GROUP_LOCK_PIN));
`default_nettype wire

// >>> bench/fsgp_host_test.sv
// testbench: protection host controller driving a behavioural flash
`timescale 1ns/10ps
`default_nettype none
module fsgp_host_test;
    import fsgp_pkg::*;
    logic CLK, RST_B, CMD_VALID, CMD_READY, DONE, VERIFY_PROT, SEC_MAPPED, HV_MODE, ERR;
    logic FLASH_CE_B, FLASH_OE_B, FLASH_WE_B, FLASH_DQ_OE_B, FLASH_RESET_HV, FLASH_RESET_B, EDGE_GROUP_LOCK_PIN;
    fsgp_op_e CMD_OP;
    logic [7:0] CMD_GROUP;
    logic [FSGP_AW-1:0] FLASH_ADDR;
    logic [FSGP_DW-1:0] FLASH_DQ_O, flash_dq;
    int n_errors = 0;
    int total_checks = 0;
    int we_falls = 0;
    logic lock_gnd = 1'b0;
    // host wins the wire only while its enable is low
    wire logic [FSGP_DW-1:0] dq_bus = !FLASH_DQ_OE_B ? FLASH_DQ_O : flash_dq;
    fsgp_host dut (.CLK(CLK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD_OP(CMD_OP), .CMD_GROUP(CMD_GROUP),
        .CMD_READY(CMD_READY), .DONE(DONE), .VERIFY_PROT(VERIFY_PROT), .SEC_MAPPED(SEC_MAPPED),
        .HV_MODE(HV_MODE), .ERR(ERR), .FLASH_CE_B(FLASH_CE_B), .FLASH_OE_B(FLASH_OE_B),
        .FLASH_WE_B(FLASH_WE_B), .FLASH_ADDR(FLASH_ADDR), .FLASH_DQ_O(FLASH_DQ_O),
        .FLASH_DQ_OE_B(FLASH_DQ_OE_B), .FLASH_DQ_I(dq_bus), .FLASH_RESET_HV(FLASH_RESET_HV),
        .FLASH_RESET_B(FLASH_RESET_B), .EDGE_GROUP_LOCK_PIN(EDGE_GROUP_LOCK_PIN));
    fsgp_flash_model u_flash (.ce_b(FLASH_CE_B), .oe_b(FLASH_OE_B), .we_b(FLASH_WE_B),
        .reset_b(FLASH_RESET_B), .addr(FLASH_ADDR), .dq_in(dq_bus), .reset_hv(FLASH_RESET_HV),
        .edge_lock_pin(lock_gnd ? 1'b0 : EDGE_GROUP_LOCK_PIN), .dq_out(flash_dq));
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    always @(negedge FLASH_WE_B) we_falls++;
    // ==========================================
    // helpers
    function automatic int gidx(input logic [7:0] g);
        return g < 4 ? int'(g) : (g > 251 ? int'(g) - 186 : 4 + (int'(g) - 4) / 4);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one command, entered and left at a falling edge
    task automatic run(input fsgp_op_e op, input logic [7:0] g);
        int n;
        n = 0;
        while (CMD_READY !== 1'b1 && n < 100) begin
            @(negedge CLK);
            n++;
        end
        CMD_VALID = 1'b1;
        CMD_OP = op;
        CMD_GROUP = g;
        @(negedge CLK);
        CMD_VALID = 1'b0;
        while (DONE !== 1'b1 && n < 400) begin
            @(negedge CLK);
            n++;
        end
        chk(n < 400, 1'b1);
        @(negedge CLK);
    endtask
    // ==========================================
    // scenarios
    initial begin
        logic [7:0] g, base, r;
        int w;
        void'($urandom(32'h9f6ebfcc));
        CMD_VALID = 1'b0;
        CMD_OP = FSGP_OP_PROTECT;
        CMD_GROUP = 8'h00;
        RST_B = 1'b0;
        repeat (2) @(negedge CLK);
        RST_B = 1'b1;
        g = 8'($urandom);
        run(FSGP_OP_VERIFY, g);
        chk(VERIFY_PROT, 1'b0);
        chk(u_flash.sec_locked, 1'b0);
        w = we_falls;
        run(FSGP_OP_UNPROTECT, g);
        chk(ERR, 1'b1);
        chk(we_falls == w, 1'b1);
        run(FSGP_OP_SEC_LOCK, g);
        chk(ERR, 1'b1);
        for (int i = 0; i < 252; i++)
            run(FSGP_OP_PROTECT, 8'(i));
        // four edge groups still open: unprotect must stay refused
        run(FSGP_OP_UNPROTECT, g);
        chk(ERR, 1'b1);
        for (int i = 252; i < 256; i++)
            run(FSGP_OP_PROTECT, 8'(i));
        run(FSGP_OP_VERIFY, g);
        chk(VERIFY_PROT, 1'b1);
        chk(u_flash.modifiable[gidx(g)], 1'b0);
        run(FSGP_OP_UNPROTECT, g);
        chk(ERR, 1'b0);
        chk(u_flash.modifiable[gidx(g)], 1'b1);
        run(FSGP_OP_VERIFY, g);
        chk(VERIFY_PROT, 1'b0);
        base = 8'(4 + 4 * ($urandom % 62));
        run(FSGP_OP_PROTECT, base | 8'($urandom % 4));
        chk(u_flash.modifiable[gidx(base)], 1'b0);
        chk(u_flash.modifiable[0], 1'b1);
        run(FSGP_OP_TEMP_ON, g);
        chk(HV_MODE, 1'b1);
        chk(FLASH_RESET_HV, 1'b1);
        chk(u_flash.modifiable[gidx(base)], 1'b1);
        lock_gnd = 1'b1;
        @(negedge CLK);
        chk(u_flash.modifiable[0], 1'b0);
        chk(u_flash.modifiable[FSGP_NUM_GROUPS-1], 1'b1);
        lock_gnd = 1'b0;
        run(FSGP_OP_TEMP_OFF, g);
        chk(HV_MODE, 1'b0);
        chk(FLASH_RESET_HV, 1'b0);
        chk(u_flash.modifiable[gidx(base)], 1'b0);
        run(FSGP_OP_SEC_ENTER, g);
        chk(SEC_MAPPED, 1'b1);
        run(FSGP_OP_SEC_LOCK, g);
        chk(ERR, 1'b0);
        chk(u_flash.sec_locked, 1'b1);
        run(FSGP_OP_SEC_EXIT, g);
        chk(SEC_MAPPED, 1'b0);
        run(FSGP_OP_SEC_ENTER, g);
        RST_B = 1'b0;
        repeat (2) @(negedge CLK);
        chk(SEC_MAPPED, 1'b0);
        chk(u_flash.sec_mapped, 1'b0);
        RST_B = 1'b1;
        for (int i = 0; i < 12; i++) begin
            r = ($urandom % 2) ? (base | 8'($urandom % 4)) : 8'($urandom);
            run(FSGP_OP_VERIFY, r);
            chk(VERIFY_PROT, gidx(r) == gidx(base));
        end
        complete_run;
    end
    initial begin
        repeat (60000) @(posedge CLK);
        n_errors++;
        complete_run;
    end
endmodule
`default_nettype wire
